/* sld_host.sv */
// host-side model: sends characters, takes answer bytes, obeys flow control
`timescale 1ns/100ps
module sld_host
  import sld_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output int              fails
);
  logic [7:0] got[$];
  logic       halted = 1'b0;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    fails    = 0;
  end

  // stop on XOFF, resume on XON
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_data == CH_XOFF)
        halted <= 1'b1;
      if (tx_data == CH_XON)
        halted <= 1'b0;
    end
    tx_ready <= !stall && !(slow && tx_ready);
  end

  // wait for XON, hold the byte until it is taken
  task automatic send(input logic [7:0] b);
    int   n;
    logic ok;
    n = 0;
    // the host never offers a reserved character
    if (b == 8'h23 || b == 8'h24 || b == 8'h21 || b == 8'h40 || b == 8'h26 || b == 8'h25)
      fails++;
    while (halted && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (halted)
      fails++;
    rx_valid <= 1'b1;
    rx_data  <= b;
    do begin
      @(negedge clk_sys);
      ok = rx_ready;
      @(posedge clk_sys);
      n++;
    end while (!ok && n < 600);
    if (!ok)
      fails++;
  endtask

  // a released line shows the inverse, not the stale character
  task automatic idle();
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule

/* sld_pkg.sv */
// constants and types for the serial line discipline
package sld_pkg;

  localparam logic [7:0] CH_BS       = 8'h08;
  localparam logic [7:0] CH_LF       = 8'h0a;
  localparam logic [7:0] CH_CR       = 8'h0d;
  localparam logic [7:0] CH_XON      = 8'h11;
  localparam logic [7:0] CH_XOFF     = 8'h13;
  localparam logic [7:0] CH_CAN      = 8'h18;
  localparam logic [7:0] CH_ESC      = 8'h1b;
  localparam logic [7:0] CH_CTRL_MAX = 8'h1f;
  localparam logic [7:0] CH_SP       = 8'h20;
  localparam logic [7:0] CH_GT       = 8'h3e;

  localparam int LINE_DEPTH = 64;
  localparam int FIFO_DEPTH = 4;

  // identification text is arbitrary, ends in CR LF
  localparam int            ID_LEN = 10;
  localparam logic [79:0]   ID_STR = {64'h534c_442d_3030_3031, CH_CR, CH_LF};

  localparam logic ECHO_RST   = 1'b1;
  localparam logic PROMPT_RST = 1'b0;
  localparam logic XON_RST    = 1'b0;

  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_CR   = 2'h1;
  localparam logic [1:0] TERM_LF   = 2'h2;

  typedef enum logic [1:0] {
    SLD_ID,
    SLD_IDLE,
    SLD_PARSE
  } sld_state_e;

endpackage

/* sld_top.sv */
// serial line discipline: receive fifo, line buffer, control codes, answers
`timescale 1ns/100ps

module sld_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sld_fifo_s;

  sld_fifo_s        f_q;
  sld_fifo_s        f_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (f_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data  = mem[f_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.wp = (f_q.wp == AW'(DEPTH-1)) ? '0 : f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = (f_q.rp == AW'(DEPTH-1)) ? '0 : f_q.rp + 1'b1;
    end
    f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[f_q.wp] <= in_data;
    end
  end
endmodule

module sld_top
  import sld_pkg::*;
#(
  parameter int LINE_DEPTH_P = sld_pkg::LINE_DEPTH,
  parameter int FIFO_DEPTH_P = sld_pkg::FIFO_DEPTH
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              rx_valid,
  input  wire logic [7:0]                        rx_data,
  output logic                                   rx_ready,
  output logic                                   tx_valid,
  output logic [7:0]                             tx_data,
  input  wire logic                              tx_ready,
  input  wire logic                              mode_wr,
  input  wire logic                              mode_echo,
  input  wire logic                              mode_prompt,
  input  wire logic                              mode_xon,
  output logic                                   echo_on,
  output logic                                   prompt_on,
  output logic                                   xon_on,
  output logic                                   cmd_start,
  output logic [$clog2(LINE_DEPTH_P):0]          cmd_len,
  input  wire logic [$clog2(LINE_DEPTH_P)-1:0]   cmd_rd_addr,
  output logic [7:0]                             cmd_rd_data,
  input  wire logic                              cmd_done,
  output logic                                   out_clear
);
  import sld_pkg::*;

  localparam int LAW = $clog2(LINE_DEPTH_P);

  typedef struct packed {
    sld_state_e  state;
    logic [31:0] seq;
    logic [2:0]  seq_n;
    logic [LAW:0] len;
    logic [3:0]  id_idx;
    logic        pend_esc;
    logic        pend_can;
    logic [1:0]  last_term;
    logic        done;
    logic        echo;
    logic        prompt;
    logic        xon;
    logic        start;
    logic        clr;
  } sld_line_s;

  sld_line_s  s_q;
  sld_line_s  s_d;
  logic [7:0] line_mem [LINE_DEPTH_P];
  logic [7:0] rd_q;
  logic       f_valid;
  logic [7:0] ch;
  logic       pop;
  logic       wr_en;
  logic       tx_fire;
  logic       is_cr;
  logic       is_lf;
  logic       is_term;
  logic [1:0] kind;
  logic       is_ctrl;
  logic       pair_second;
  logic       line_full;

  // depth of four rides out one answer burst; the engine stalls while it sends
  sld_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH_P)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_data   (rx_data),
    .in_ready  (rx_ready),
    .out_valid (f_valid),
    .out_data  (ch),
    .out_ready (pop)
  );

  assign tx_valid    = (s_q.seq_n != 3'h0);
  assign tx_data     = s_q.seq[7:0];
  assign tx_fire     = tx_valid && tx_ready;
  assign echo_on     = s_q.echo;
  assign prompt_on   = s_q.prompt;
  assign xon_on      = s_q.xon;
  assign cmd_start   = s_q.start;
  assign cmd_len     = s_q.len;
  assign cmd_rd_data = rd_q;
  assign out_clear   = s_q.clr;

  assign is_cr       = (ch == CH_CR);
  assign is_lf       = (ch == CH_LF);
  assign is_term     = is_cr || is_lf;
  assign kind        = is_cr ? TERM_CR : TERM_LF;
  assign is_ctrl     = (ch <= CH_CTRL_MAX);
  assign pair_second = (s_q.last_term != TERM_NONE) && (s_q.last_term != kind);
  assign line_full   = (s_q.len == (LAW+1)'(LINE_DEPTH_P));
  // input is only consumed when no answer is still going out
  assign pop         = (s_q.state == SLD_IDLE) && (s_q.seq_n == 3'h0) && f_valid;
  // a pending escape or cancel only matters for LF, so printable input is stored as counted
  assign wr_en       = pop && !is_ctrl && !line_full;

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    s_d.clr   = 1'b0;
    if (tx_fire) begin
      s_d.seq   = {8'h00, s_q.seq[31:8]};
      s_d.seq_n = s_q.seq_n - 3'h1;
    end
    if (mode_wr) begin
      s_d.echo   = mode_echo;
      s_d.prompt = mode_prompt;
      s_d.xon    = mode_xon;
    end
    unique case (s_q.state)
      SLD_ID: begin
        if (s_q.seq_n == 3'h0) begin
          if (s_q.id_idx == 4'(ID_LEN)) begin
            s_d.state = SLD_IDLE;
          end else begin
            s_d.seq    = {24'h0, ID_STR[8*(ID_LEN-1-int'(s_q.id_idx)) +: 8]};
            s_d.seq_n  = 3'h1;
            s_d.id_idx = s_q.id_idx + 4'h1;
          end
        end
      end
      SLD_IDLE: begin
        if (pop) begin
          if ((s_q.pend_esc || s_q.pend_can) && is_lf) begin
            // escape or cancel confirmed by LF
            s_d.pend_esc  = 1'b0;
            s_d.pend_can  = 1'b0;
            s_d.last_term = TERM_NONE;
            // clear input line, answer CR LF
            s_d.len   = '0;
            s_d.seq   = {16'h0, CH_LF, CH_CR};
            s_d.seq_n = 3'h2;
            // cancel also clears the output side
            s_d.clr   = s_q.pend_can;
          end else begin
            s_d.pend_esc = 1'b0;
            s_d.pend_can = 1'b0;
            if (is_term) begin
              if (pair_second) begin
                // second of a CR LF pair is swallowed
                s_d.last_term = TERM_NONE;
              end else begin
                s_d.last_term = kind;
                if (s_q.xon) begin
                  s_d.seq   = s_q.echo ? {16'h0, CH_CR, CH_XOFF} : {24'h0, CH_XOFF};
                  s_d.seq_n = s_q.echo ? 3'h2 : 3'h1;
                end else if (s_q.echo) begin
                  s_d.seq   = {24'h0, ch};
                  s_d.seq_n = 3'h1;
                end
                s_d.start = 1'b1;
                s_d.done  = 1'b0;
                s_d.state = SLD_PARSE;
              end
            end else begin
              s_d.last_term = TERM_NONE;
              if (ch == CH_BS) begin
                if (s_q.len != '0) begin
                  s_d.len = s_q.len - 1'b1;
                end
                if (s_q.echo) begin
                  s_d.seq   = {8'h0, CH_BS, CH_SP, CH_BS};
                  s_d.seq_n = 3'h3;
                end
              end else if (ch == CH_ESC) begin
                s_d.pend_esc = 1'b1;
              end else if (ch == CH_CAN) begin
                s_d.pend_can = 1'b1;
              end else if (!is_ctrl) begin
                // echo printable input; a full line drops it unechoed
                if (!line_full) begin
                  s_d.len = s_q.len + 1'b1;
                  if (s_q.echo) begin
                    s_d.seq   = {24'h0, ch};
                    s_d.seq_n = 3'h1;
                  end
                end
              end
              // any other control code is dropped
            end
          end
        end
      end
      SLD_PARSE: begin
        if (cmd_done) begin
          s_d.done = 1'b1;
        end
        if ((cmd_done || s_q.done) && s_q.seq_n == 3'h0) begin
          s_d.state = SLD_IDLE;
          s_d.done  = 1'b0;
          s_d.len   = '0;
          if (s_q.prompt) begin
            s_d.seq   = {8'h0, CH_GT, CH_LF, CH_CR};
            s_d.seq_n = 3'h3;
          end else if (s_q.echo && s_q.xon) begin
            // CR LF completion, then XON to resume the host
            s_d.seq   = {8'h0, CH_XON, CH_LF, CH_CR};
            s_d.seq_n = 3'h3;
          end else if (s_q.echo) begin
            s_d.seq   = {24'h0, CH_LF};
            s_d.seq_n = 3'h1;
          end else begin
            s_d.seq   = {24'h0, CH_XON};
            s_d.seq_n = 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q        <= '0;
      s_q.state  <= SLD_ID;
      s_q.echo   <= ECHO_RST;
      s_q.prompt <= PROMPT_RST;
      s_q.xon    <= XON_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      line_mem[s_q.len[LAW-1:0]] <= ch;
    end
    rd_q <= line_mem[cmd_rd_addr];
  end

  start_cause_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(cmd_start) |-> $past(pop && is_term && !pair_second)
  ) else $error("parse started without a terminator");

  id_first_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> ##[1:3] (tx_valid && tx_data == ID_STR[79:72])
  ) else $error("identification not sent after reset");

  ctrl_drop_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && is_ctrl && !is_term && ch != CH_BS && ch != CH_ESC && ch != CH_CAN
     && !s_q.pend_esc && !s_q.pend_can)
    |=> (s_q.seq_n == 3'h0 && s_q.len == $past(s_q.len) && !cmd_start)
  ) else $error("stray control code acted on");

  bs_del_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && ch == CH_BS && !s_q.pend_esc && !s_q.pend_can && s_q.len != '0)
    |=> (s_q.len == $past(s_q.len) - 1'b1)
  ) else $error("backspace did not delete");

  bs_echo_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && ch == CH_BS && !s_q.pend_esc && !s_q.pend_can && s_q.echo)
    |=> (s_q.seq_n == 3'h3 && s_q.seq[23:0] == {CH_BS, CH_SP, CH_BS})
  ) else $error("backspace echo wrong");

  esc_clear_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && s_q.pend_esc && is_lf)
    |=> (s_q.len == '0 && s_q.seq_n == 3'h2 && s_q.seq[15:0] == {CH_LF, CH_CR} && !out_clear)
  ) else $error("escape did not clear line");

  can_clear_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && s_q.pend_can && is_lf) |=> (out_clear && s_q.len == '0) ##1 !out_clear
  ) else $error("cancel did not clear buffers");

  echo_char_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && !is_ctrl && !s_q.pend_esc && !s_q.pend_can && s_q.echo && !line_full)
    |=> (s_q.seq_n == 3'h1 && tx_data == $past(ch))
  ) else $error("character not echoed");

  pair_drop_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && is_term && pair_second && !s_q.pend_esc && !s_q.pend_can)
    |=> (s_q.seq_n == 3'h0 && !cmd_start)
  ) else $error("second terminator of a pair echoed");

  xoff_term_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pop && is_term && !pair_second && s_q.xon && !s_q.pend_esc && !s_q.pend_can)
    |=> (tx_data == CH_XOFF && s_q.seq_n == ($past(s_q.echo) ? 3'h2 : 3'h1))
  ) else $error("terminator not answered with XOFF");

  prompt_seq_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.state == SLD_PARSE && s_q.seq_n == 3'h0 && (cmd_done || s_q.done) && s_q.prompt)
    |=> (s_q.seq_n == 3'h3 && s_q.seq[23:0] == {CH_GT, CH_LF, CH_CR})
  ) else $error("prompt sequence wrong");

  post_plain_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (s_q.state == SLD_PARSE && s_q.seq_n == 3'h0 && (cmd_done || s_q.done)
     && !s_q.prompt && !s_q.xon)
    |=> (s_q.seq_n == 3'h1 && tx_data == ($past(s_q.echo) ? CH_LF : CH_XON))
  ) else $error("completion answer wrong");
endmodule

/* tb.sv */
// self-checking bench for the serial line discipline
`timescale 1ns/100ps
module tb;
  import sld_pkg::*;
  logic       clk_sys     = 1'b0;
  logic       rst         = 1'b1;
  logic       stall       = 1'b0;
  logic       slow        = 1'b0;
  logic       mode_wr     = 1'b0;
  logic       mode_echo   = 1'b1;
  logic       mode_prompt = 1'b0;
  logic       mode_xon    = 1'b0;
  logic       cmd_done    = 1'b0;
  logic [5:0] cmd_rd_addr = 6'h00;
  logic       rx_valid, rx_ready, tx_valid, tx_ready;
  logic       echo_on, prompt_on, xon_on, cmd_start, out_clear;
  logic [7:0] rx_data, tx_data, cmd_rd_data;
  logic [6:0] cmd_len, len_seen;
  int         error_cnt   = 0;
  int         checks      = 0;
  int         starts      = 0;
  int         clears      = 0;
  int         fails;

  always #5 clk_sys = ~clk_sys;

  sld_top #(.LINE_DEPTH_P(LINE_DEPTH), .FIFO_DEPTH_P(FIFO_DEPTH)) i_sld_top (
    .clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .mode_wr(mode_wr), .mode_echo(mode_echo), .mode_prompt(mode_prompt),
    .mode_xon(mode_xon), .echo_on(echo_on), .prompt_on(prompt_on), .xon_on(xon_on),
    .cmd_start(cmd_start), .cmd_len(cmd_len), .cmd_rd_addr(cmd_rd_addr),
    .cmd_rd_data(cmd_rd_data), .cmd_done(cmd_done), .out_clear(out_clear));

  sld_host i_sld_host (
    .clk_sys(clk_sys), .stall(stall), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .fails(fails));

  always @(posedge clk_sys) begin
    if (cmd_start) begin
      starts   <= starts + 1;
      len_seen <= cmd_len;
    end
    if (out_clear)
      clears <= clears + 1;
  end

  task automatic test_done();
    error_cnt += fails;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one line out, whole answer back before the next line goes
  task automatic run_line(input logic [7:0] s[$], input logic [7:0] e[$], input int st,
                          input logic [6:0] len);
    int s0;
    int n;
    s0 = starts;
    i_sld_host.got.delete();
    foreach (s[i])
      i_sld_host.send(s[i]);
    i_sld_host.idle();
    for (n = 0; n < 40 && starts == s0; n++)
      @(posedge clk_sys);
    check(8'(starts - s0), 8'(st));
    if (starts != s0) begin
      check({1'b0, len_seen}, {1'b0, len});
      cmd_rd_addr <= 6'h00;
      repeat (2) @(posedge clk_sys);
      if (s[0] > CH_CTRL_MAX)
        check(cmd_rd_data, s[0]);
      cmd_done <= 1'b1;
      @(posedge clk_sys);
      cmd_done <= 1'b0;
    end
    for (n = 0; n < 100 && i_sld_host.got.size() < e.size(); n++)
      @(posedge clk_sys);
    if (i_sld_host.got.size() < e.size())
      timeout();
    repeat (8) @(posedge clk_sys);
    check(8'(i_sld_host.got.size()), 8'(e.size()));
    foreach (e[i])
      check(i_sld_host.got[i], e[i]);
  endtask

  task automatic set_mode(input logic e, input logic p, input logic x);
    mode_wr     <= 1'b1;
    mode_echo   <= e;
    mode_prompt <= p;
    mode_xon    <= x;
    @(posedge clk_sys);
    mode_wr <= 1'b0;
    @(posedge clk_sys);
    check({5'h00, echo_on, prompt_on, xon_on}, {5'h00, e, p, x});
  endtask

  task automatic t_id();
    int n;
    for (n = 0; n < 200 && i_sld_host.got.size() < ID_LEN; n++)
      @(posedge clk_sys);
    if (i_sld_host.got.size() < ID_LEN)
      timeout();
    for (int i = 0; i < ID_LEN; i++)
      check(i_sld_host.got[i], ID_STR[79-8*i -: 8]);
    check({5'h00, echo_on, prompt_on, xon_on}, 8'h04);
  endtask

  task automatic t_lines();
    run_line('{8'h41, 8'h42, CH_CR}, '{8'h41, 8'h42, CH_CR, CH_LF}, 1, 7'd2);
    run_line('{8'h41, 8'h42, CH_BS, CH_LF, CH_CR},
             '{8'h41, 8'h42, CH_BS, CH_SP, CH_BS, CH_LF, CH_LF}, 1, 7'd1);
    run_line('{8'h43, 8'h01, 8'h07, CH_CTRL_MAX, CH_LF},
             '{8'h43, CH_LF, CH_LF}, 1, 7'd1);
  endtask

  task automatic t_clear();
    int c0;
    c0 = clears;
    run_line('{8'h44, CH_ESC, 8'h46, CH_LF}, '{8'h44, 8'h46, CH_LF, CH_LF}, 1, 7'd2);
    // the character after a dropped escape must land in the line too
    cmd_rd_addr <= 6'h01;
    repeat (2) @(posedge clk_sys);
    check(cmd_rd_data, 8'h46);
    run_line('{8'h47, CH_ESC, CH_LF}, '{8'h47, CH_CR, CH_LF}, 0, 7'd0);
    run_line('{8'h48, CH_CAN, CH_LF}, '{8'h48, CH_CR, CH_LF}, 0, 7'd0);
    check(8'(clears - c0), 8'h01);
    run_line('{8'h49, CH_LF}, '{8'h49, CH_LF, CH_LF}, 1, 7'd1);
  endtask

  // stalled answers back up into the 4-deep fifo until it refuses
  task automatic t_fifo();
    stall <= 1'b1;
    for (int i = 0; i < 5; i++)
      i_sld_host.send(8'h41 + 8'(i));
    i_sld_host.idle();
    repeat (4) @(posedge clk_sys);
    check({7'h00, rx_ready}, 8'h00);
    stall <= 1'b0;
    run_line('{CH_LF}, '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, CH_LF, CH_LF}, 1, 7'd5);
  endtask

  task automatic t_modes();
    set_mode(1'b1, 1'b1, 1'b0);
    slow <= 1'b1;
    run_line('{8'h4b, CH_CR}, '{8'h4b, CH_CR, CH_CR, CH_LF, CH_GT}, 1, 7'd1);
    slow <= 1'b0;
    set_mode(1'b1, 1'b0, 1'b1);
    run_line('{8'h4d, CH_CR},
             '{8'h4d, CH_XOFF, CH_CR, CH_CR, CH_LF, CH_XON}, 1, 7'd1);
    set_mode(1'b0, 1'b0, 1'b1);
    run_line('{8'h4e, CH_LF}, '{CH_XOFF, CH_XON}, 1, 7'd1);
    set_mode(1'b0, 1'b0, 1'b0);
    run_line('{8'h50, CH_LF}, '{CH_XON}, 1, 7'd1);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_id();
    t_lines();
    t_clear();
    t_fifo();
    t_modes();
    test_done();
  end
endmodule
